//--- src/dps_seq.sv
`include "dps_params.svh"

// Function
// - Reset low: flash clock, data, selects and GPIO pins are released.
// - Reset low: illumination selects and mirror enable driven low.
// - Reset release activates all I/Os and starts initialization.
// - Initialization locks PLL first, then loads flash configuration.
// - After release, status output driven high during initialization.
// - Initialization done drives status output low.
// - Mirror parking completes within 20 ms of enable falling.
// - Reset after parking releases status output to pull-up.
// - Fast-park request low starts a fast park from ready or from a normal park.
// - Core power lost: host-supply outputs go high impedance.
// - Enable high in off returns to ready; enable falling in ready parks to off.
module dps_seq #(
  parameter int NORMAL_PARK_CYC = `DPS_NORMAL_PARK_CYC,
  parameter int FAST_PARK_CYC = `DPS_FAST_PARK_CYC,
  parameter int PLL_WAIT_CYC = `DPS_PLL_WAIT_CYC,
  parameter int FLASH_LOAD_CYC = `DPS_FLASH_LOAD_CYC,
  parameter int GPIO_W = `DPS_GPIO_W
) (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Power-management side.
  input wire logic system_reset_n_i,
  input wire logic fast_park_request_n_i,
  input wire logic core_power_good_i,
  // Host side.
  input wire logic projector_enable_i,
  output logic init_status_o,
  output logic init_status_oe_n_o,
  // Internal lock status from PLL.
  input wire logic pll_lock_i,
  // Flash pins (output enables active low).
  output logic flash_serial_clock_o,
  output logic flash_serial_clock_oe_n_o,
  output logic flash_serial_data_out_o,
  output logic flash_serial_data_out_oe_n_o,
  output logic flash_select0_n_o,
  output logic flash_select0_n_oe_n_o,
  output logic flash_select1_n_o,
  output logic flash_select1_n_oe_n_o,
  output logic [GPIO_W-1:0] gpio_oe_n_o,
  // Mirror and illumination.
  output logic illum_select0_o,
  output logic illum_select1_o,
  output logic mirror_enable_reset_n_o,
  // Sequencer status.
  output logic frame_ready_o,
  output logic parking_o,
  output logic park_done_o
);
  localparam int TW = 21;

  // Refuse counts that the shared timer cannot hold.
  if (NORMAL_PARK_CYC < 1 || NORMAL_PARK_CYC >= (1 << TW)) begin
    $error("NORMAL_PARK_CYC out of range");
  end
  if (FAST_PARK_CYC < 1 || FAST_PARK_CYC >= NORMAL_PARK_CYC) begin
    $error("FAST_PARK_CYC out of range");
  end
  if (FLASH_LOAD_CYC < 1 || FLASH_LOAD_CYC >= (1 << TW)) begin
    $error("FLASH_LOAD_CYC out of range");
  end
  if (PLL_WAIT_CYC < 1) begin
    $error("PLL_WAIT_CYC out of range");
  end
  if (GPIO_W < 1) begin
    $error("GPIO_W out of range");
  end

  // ****************************************
  // State and event decode
  // ****************************************
  dps_pkg::dps_state_e state_ff;
  dps_pkg::dps_state_e nxt_state;
  logic proj_ff;
  logic out_en_ff;
  logic status_ff;
  logic status_drv_ff;
  logic done_ff;
  logic timer_done;
  logic timer_start;
  logic [TW-1:0] timer_load;
  logic proj_fall;
  logic fast_req;
  logic in_reset;
  logic io_active;

  // Reset on the pin acts on the sequencer synchronously.
  assign in_reset = ~system_reset_n_i;
  assign proj_fall = proj_ff & ~projector_enable_i;
  assign fast_req = ~fast_park_request_n_i;
  // Outputs lose drive when core power fails, whatever the state.
  assign io_active = out_en_ff & core_power_good_i;

  // Next-state logic; fast park outranks normal park.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      dps_pkg::ST_RESET: nxt_state = dps_pkg::ST_PLL;
      dps_pkg::ST_PLL: if (pll_lock_i) nxt_state = dps_pkg::ST_LOAD;
      dps_pkg::ST_LOAD: if (timer_done) nxt_state = dps_pkg::ST_READY;
      dps_pkg::ST_READY: begin
        if (fast_req) nxt_state = dps_pkg::ST_FPARK;
        else if (proj_fall) nxt_state = dps_pkg::ST_PARK;
      end
      dps_pkg::ST_PARK: begin
        if (fast_req) nxt_state = dps_pkg::ST_FPARK;
        else if (timer_done) nxt_state = dps_pkg::ST_OFF;
      end
      dps_pkg::ST_FPARK: if (timer_done) nxt_state = dps_pkg::ST_OFF;
      dps_pkg::ST_OFF: if (projector_enable_i && !fast_req) begin
        nxt_state = dps_pkg::ST_READY;
      end
      default: nxt_state = dps_pkg::ST_RESET;
    endcase
    if (in_reset) nxt_state = dps_pkg::ST_RESET;
  end

  // Timer loads on each entry into a timed state.
  assign timer_start = (nxt_state != state_ff) &&
                       (nxt_state == dps_pkg::ST_LOAD ||
                        nxt_state == dps_pkg::ST_PARK ||
                        nxt_state == dps_pkg::ST_FPARK);
  assign timer_load = (nxt_state == dps_pkg::ST_LOAD) ?
                      TW'(FLASH_LOAD_CYC - 1) :
                      (nxt_state == dps_pkg::ST_FPARK) ?
                      TW'(FAST_PARK_CYC - 1) : TW'(NORMAL_PARK_CYC - 1);

  dps_timer #(
    .W(TW)
  ) u_timer (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i | in_reset),
    .start_i(timer_start),
    .load_i(timer_load),
    .done_o(timer_done)
  );

  // ****************************************
  // Registers
  // ****************************************
  // State, enable sample and output controls.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      state_ff <= dps_pkg::ST_RESET;
      proj_ff <= 1'b0;
      out_en_ff <= 1'b0;
      status_ff <= 1'b1;
      status_drv_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      proj_ff <= projector_enable_i;
      out_en_ff <= ~in_reset;
      status_drv_ff <= ~in_reset;
      status_ff <= (nxt_state == dps_pkg::ST_RESET ||
                    nxt_state == dps_pkg::ST_PLL ||
                    nxt_state == dps_pkg::ST_LOAD);
      done_ff <= (nxt_state == dps_pkg::ST_OFF);
    end
  end

  // ****************************************
  // Pin drive
  // ****************************************
  // Tri-state group released in reset; flash idles deselected.
  assign flash_serial_clock_o = 1'b0;
  assign flash_serial_data_out_o = 1'b0;
  assign flash_select0_n_o = 1'b1;
  assign flash_select1_n_o = 1'b1;
  assign flash_serial_clock_oe_n_o = ~io_active;
  assign flash_serial_data_out_oe_n_o = ~io_active;
  assign flash_select0_n_oe_n_o = ~io_active;
  assign flash_select1_n_oe_n_o = ~io_active;
  assign gpio_oe_n_o = {GPIO_W{~io_active}};

  // Status line: driven only out of reset; pull-up holds it otherwise.
  assign init_status_o = status_ff;
  assign init_status_oe_n_o = ~(status_drv_ff & io_active);

  // Illumination selects always low; mirror enable low until ready.
  assign illum_select0_o = 1'b0;
  assign illum_select1_o = 1'b0;
  assign mirror_enable_reset_n_o = io_active &&
                                   state_ff == dps_pkg::ST_READY;
  assign frame_ready_o = (state_ff == dps_pkg::ST_READY);
  assign parking_o = (state_ff == dps_pkg::ST_PARK) ||
                     (state_ff == dps_pkg::ST_FPARK);
  assign park_done_o = done_ff;

  // ****************************************
  // Assertions
  // ****************************************
  // Cycles spent in the current state; a counter keeps the park limits
  // cheap where a long delay range would slow the tools down.
  logic [TW-1:0] dwell_ff;
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || nxt_state != state_ff) begin
      dwell_ff <= '0;
    end else begin
      dwell_ff <= dwell_ff + 1'b1;
    end
  end

  a_reset_tristate: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    !system_reset_n_i |=> gpio_oe_n_o[0] && flash_select0_n_oe_n_o)
    else $error("pins driven during reset");
  a_reset_low: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    !system_reset_n_i |=> !mirror_enable_reset_n_o && !illum_select0_o)
    else $error("mirror enable high in reset");
  a_release_active: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    $rose(system_reset_n_i) && core_power_good_i ##0
    system_reset_n_i [*2] |-> !gpio_oe_n_o[0])
    else $error("I/O not active after release");
  a_pll_first: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    state_ff == dps_pkg::ST_LOAD && $past(state_ff) != dps_pkg::ST_LOAD
    |-> $past(state_ff) == dps_pkg::ST_PLL && $past(pll_lock_i))
    else $error("flash load before PLL lock");
  a_status_high: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    state_ff == dps_pkg::ST_PLL && core_power_good_i
    |-> init_status_o && !init_status_oe_n_o)
    else $error("status not driven high during init");
  a_status_done: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    state_ff == dps_pkg::ST_READY |-> !init_status_o)
    else $error("status not low when ready");
  a_status_release: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    !system_reset_n_i |=> init_status_oe_n_o)
    else $error("status driven in reset");
  a_fast_park: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    state_ff == dps_pkg::ST_READY && fast_req && system_reset_n_i
    |=> state_ff == dps_pkg::ST_FPARK)
    else $error("fast park not taken");
  a_core_loss: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    !core_power_good_i |-> gpio_oe_n_o[0] && init_status_oe_n_o)
    else $error("outputs driven without core power");
  a_park_time: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    state_ff == dps_pkg::ST_FPARK |-> dwell_ff < TW'(FAST_PARK_CYC))
    else $error("fast park too long");
  a_normal_time: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    state_ff == dps_pkg::ST_PARK |-> dwell_ff < TW'(NORMAL_PARK_CYC))
    else $error("normal park too long");
  c_init: cover property (@(posedge clock_i) state_ff == dps_pkg::ST_READY);
  c_park: cover property (@(posedge clock_i) state_ff == dps_pkg::ST_PARK);
  c_fpark: cover property (@(posedge clock_i) state_ff == dps_pkg::ST_FPARK);
  c_off: cover property (@(posedge clock_i) park_done_o);
endmodule

//--- src/dps_params.svh
`ifndef DPS_PARAMS_SVH
`define DPS_PARAMS_SVH

// Clock period in picoseconds (100 MHz).
`define DPS_CLK_PERIOD_PS 10_000
// Normal park completes within this time, in microseconds.
`define DPS_NORMAL_PARK_US 20_000
// Fast park completes within this time, in nanoseconds.
`define DPS_FAST_PARK_NS 32_000
// Longest times round down to whole cycles.
`define DPS_NORMAL_PARK_CYC \
  ((`DPS_NORMAL_PARK_US * 1000) / (`DPS_CLK_PERIOD_PS / 1000))
`define DPS_FAST_PARK_CYC ((`DPS_FAST_PARK_NS) / (`DPS_CLK_PERIOD_PS / 1000))
// Default number of cycles to load configuration from flash.
`define DPS_FLASH_LOAD_CYC 256
// Default PLL lock wait in cycles.
`define DPS_PLL_WAIT_CYC 64
// Width of general-purpose pin group.
`define DPS_GPIO_W 20

`endif

//--- src/dps_pkg.sv
package dps_pkg;
  // Sequencer states.
  typedef enum logic [2:0] {
    ST_RESET,
    ST_PLL,
    ST_LOAD,
    ST_READY,
    ST_PARK,
    ST_FPARK,
    ST_OFF
  } dps_state_e;
endpackage

//--- src/dps_timer.sv
`include "dps_params.svh"

// Down-counter: loads on start, flags done when it reaches zero.
module dps_timer #(
  parameter int W = 21
) (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Control.
  input wire logic start_i,
  input wire logic [W-1:0] load_i,
  // Status.
  output logic done_o
);
  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;
  logic run_ff;
  logic nxt_run;

  // Refuse a width too narrow to hold a useful count.
  if (W < 2) begin
    $error("dps_timer width too small");
  end

  // Count down while running; done is a one-cycle pulse at zero.
  assign nxt_cnt = start_i ? load_i : (run_ff ? cnt_ff - 1'b1 : cnt_ff);
  assign nxt_run = start_i | (run_ff & (cnt_ff != '0));
  assign done_o = run_ff & (cnt_ff == '0) & ~start_i;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      cnt_ff <= '0;
      run_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      run_ff <= nxt_run;
    end
  end
endmodule

//--- tb/dps_pwr_model.sv
// ****************************************
// Power monitor model for the sequencer.
// ****************************************
module dps_pwr_model #(
  parameter int HOLD_CYC = 50
) (
  // Clock and stimulus.
  input wire logic clock_i,
  input wire logic supply_on_i,
  input wire logic fault_i,
  input wire logic park_done_i,
  // Power-side pins.
  output logic system_reset_n_o,
  output logic fast_park_request_n_o,
  output logic core_power_good_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt = 0;
  initial begin
    system_reset_n_o = 1'b0;
    fast_park_request_n_o = 1'b1;
    core_power_good_o = 1'b0;
  end
  // Supplies and reset move 2 ns after the edge, after the bench inputs
  // have settled, so the model never races the bench in one time step.
  // Reset is asserted once parking is done or when the supply drops, so the supplies and
  // clock outlast either park window.
  always @(posedge clock_i) begin
    #2;
    core_power_good_o = supply_on_i;
    if (!supply_on_i) begin
      cnt = 0;
      system_reset_n_o = 1'b0;
      fast_park_request_n_o = 1'b1;
    end else begin
      if (fault_i) fast_park_request_n_o = 1'b0;
      if (cnt == HOLD_CYC - 1 && fast_park_request_n_o) begin
        system_reset_n_o = 1'b1;
      end
      if (cnt < HOLD_CYC) cnt++;
      if (park_done_i) system_reset_n_o = 1'b0;
    end
  end
endmodule

//--- tb/tb_top.sv
// ****************************************
// Sequencer bench.
// ****************************************
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {int code; int dl;} dps_note_s;
  localparam int NPARK = 100;
  localparam int FPARK = 20;
  localparam int FLOAD = 256;
  // Battery hold after a normal park, scaled like the park window.
  localparam int BATT = NPARK * 5 / 2;
  logic clock_i = 0, sys_rst_i = 1, proj_en = 0, pll_lock = 0;
  logic supply_on = 0, fault = 0, fr_q = 0, pd_q = 0;
  logic rst_n, fpark_n, pgood, init_st, init_oe_n, fclk_oe_n, fdat_oe_n;
  logic cs0_oe_n, cs1_oe_n, il0, il1, mir, fr, parking, pdone;
  logic [19:0] gpio_oe_n;
  logic fclk, fdat, cs0, cs1;
  int errors = 0, checks = 0, cyc = 0;
  dps_note_s notes[$];
  dps_note_s nt;
  dps_seq #(.NORMAL_PARK_CYC(NPARK), .FAST_PARK_CYC(FPARK),
    .FLASH_LOAD_CYC(FLOAD)) uut (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .system_reset_n_i(rst_n), .fast_park_request_n_i(fpark_n),
    .core_power_good_i(pgood), .projector_enable_i(proj_en),
    .init_status_o(init_st), .init_status_oe_n_o(init_oe_n),
    .pll_lock_i(pll_lock), .flash_serial_clock_o(fclk),
    .flash_serial_clock_oe_n_o(fclk_oe_n), .flash_serial_data_out_o(fdat),
    .flash_serial_data_out_oe_n_o(fdat_oe_n), .flash_select0_n_o(cs0),
    .flash_select0_n_oe_n_o(cs0_oe_n), .flash_select1_n_o(cs1),
    .flash_select1_n_oe_n_o(cs1_oe_n), .gpio_oe_n_o(gpio_oe_n),
    .illum_select0_o(il0), .illum_select1_o(il1),
    .mirror_enable_reset_n_o(mir), .frame_ready_o(fr),
    .parking_o(parking), .park_done_o(pdone));
  dps_pwr_model pwr (
    .clock_i(clock_i), .supply_on_i(supply_on), .fault_i(fault),
    .park_done_i(pdone), .system_reset_n_o(rst_n),
    .fast_park_request_n_o(fpark_n), .core_power_good_o(pgood));
  // Free-running clock.
  initial begin
    forever #5 clock_i = ~clock_i;
  end
  task automatic close_out();
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  function automatic logic pick(input int w);
    return (w == 0) ? rst_n : (w == 1) ? fr : pdone;
  endfunction
  // Bounded wait so a stuck sequencer cannot hang the run.
  task automatic wait_on(input int w, input logic lvl);
    int n;
    n = 0;
    while (pick(w) !== lvl && n < 2000) begin
      tick(1);
      n++;
    end
    check(n < 2000, 1);
  endtask
  // Cycle count and hang guard.
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 6000) begin
      errors++;
      close_out();
    end
  end
  // Results are judged at the falling edge, where outputs have settled.
  always @(negedge clock_i) begin
    if ((fr && !fr_q) || (pdone && !pd_q)) begin
      if (notes.size() == 0) begin
        check(0, 1);
      end else begin
        nt = notes.pop_front();
        check(fr ? 1 : 2, nt.code);
        check(cyc, nt.dl);
      end
    end
    fr_q = fr;
    pd_q = pdone;
  end
  // Host holds enable high until the status goes low, and sends no
  // traffic before then.
  task automatic power_up();
    pll_lock = 0;
    supply_on = 1;
    proj_en = 1;
    wait_on(0, 1);
    tick(2);
    check({init_oe_n, init_st, fclk_oe_n}, 3'b010);
    check({fclk, fdat, cs0, cs1}, 4'h3);
    tick($urandom_range(40, 5));
    check(fr, 0);
    pll_lock = 1;
    notes.push_back('{1, cyc + FLOAD + 1});
    wait_on(1, 1);
    tick(1);
    check({init_st, mir}, 2'b01);
  endtask
  // Main sequence: normal park, then fast park racing a normal one.
  initial begin
    void'($urandom(32'hb70b));
    repeat (16) @(posedge clock_i);
    #1 sys_rst_i = 0;
    tick(3);
    check(&gpio_oe_n, 1);
    check({fclk_oe_n, fdat_oe_n, cs0_oe_n, cs1_oe_n}, 4'hf);
    check({il0, il1, mir}, 3'h0);
    power_up();
    proj_en = 0;
    notes.push_back('{2, cyc + NPARK + 1});
    tick(2);
    check(parking, 1);
    wait_on(2, 1);
    check(fr, 0);
    wait_on(0, 0);
    tick(2);
    check({init_oe_n, il0, il1, mir}, 4'h8);
    tick(BATT);
    supply_on = 0;
    tick(3);
    power_up();
    fault = 1;
    proj_en = 0;
    notes.push_back('{2, cyc + FPARK + 1});
    wait_on(2, 1);
    fault = 0;
    supply_on = 0;
    tick(3);
    check(&gpio_oe_n, 1);
    close_out();
  end
endmodule
